// file: tcbr_timer_regs.sv
// Buffered 16-bit timer register set with byte-wide access through a shared latch
// Functional notes
// - Shared read/write 8-bit byte latch register
// - Low byte at base, high byte next
// - Counter at 0x20, resets to zero
// - Period sets TOP except frequency mode
// - Three compare registers matched against counter
// - Update loads compare from its shadow
// - Period shadow write sets its valid flag
// - Compare shadow write sets channel valid flag
// - Match sets sticky flag; write one clears unless the channel matches in that cycle
`timescale 1ns/1ps
module tcbr_timer_regs #(
    parameter int unsigned NUM_CHAN = tcbr_pkg::TCBR_NUM_CHAN
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire tcbr_pkg::tcbr_bus_req_type bus_i,
    input wire logic count_tick_i,
    input wire logic frequency_waveform_mode_i,
    output logic [7:0] rdata_o,
    output logic [15:0] count_value_o,
    output logic [NUM_CHAN-1:0] match_o,
    output logic [NUM_CHAN-1:0] match_flag_o,
    output logic update_o
);
    import tcbr_pkg::*;

    tcbr_decode_type dec;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic [15:0] wword;
    logic [15:0] sel16;
    logic [7:0] rd_next;

    logic [7:0] temp_q;
    logic [15:0] count_q;
    logic [7:0] rdata_q;
    logic update_q;

    logic [15:0] cycle_length;
    logic [15:0] cycle_length_shadow;
    logic cycle_length_shadow_valid;
    logic [15:0] match_value_n [NUM_CHAN];
    logic [15:0] match_value_shadow_n [NUM_CHAN];
    logic [NUM_CHAN-1:0] match_shadow_valid_n;
    logic [NUM_CHAN-1:0] match_q;
    logic [NUM_CHAN-1:0] flag_q;
    logic [NUM_CHAN-1:0] flag_clear;

    logic count_we;
    logic per_we;
    logic pbuf_we;
    logic [NUM_CHAN-1:0] cmp_we;
    logic [NUM_CHAN-1:0] cbuf_we;
    logic [15:0] top_value;
    logic at_top;
    logic update;
    logic [7:0] buffer_valid_control;
    logic [7:0] flag_byte;

    assign dec = tcbr_decode(bus_i.addr);

    assign wr_lo = bus_i.wr && !dec.high;
    assign wr_hi = bus_i.wr && dec.high;
    assign rd_lo = bus_i.rd && !bus_i.wr && !dec.high;

    // high byte commits latched low byte
    assign wword = {bus_i.wdata, temp_q};

    always_comb begin
        count_we = 1'b0;
        per_we = 1'b0;
        pbuf_we = 1'b0;
        cmp_we = '0;
        cbuf_we = '0;
        if (wr_hi) begin
            if (dec.target == TCBR_T_COUNT) begin
                count_we = 1'b1;
            end else if (dec.target == TCBR_T_PER) begin
                per_we = 1'b1;
            end else if (dec.target == TCBR_T_PBUF) begin
                pbuf_we = 1'b1;
            end else if (dec.target == TCBR_T_CMP) begin
                cmp_we[dec.chan] = 1'b1;
            end else if (dec.target == TCBR_T_CBUF) begin
                cbuf_we[dec.chan] = 1'b1;
            end
        end
    end

    // Selected 16-bit register for reads
    always_comb begin
        sel16 = 16'h0000;
        if (dec.target == TCBR_T_COUNT) begin
            sel16 = count_q;
        end else if (dec.target == TCBR_T_PER) begin
            sel16 = cycle_length;
        end else if (dec.target == TCBR_T_PBUF) begin
            sel16 = cycle_length_shadow;
        end else if (dec.target == TCBR_T_CMP) begin
            sel16 = match_value_n[dec.chan];
        end else if (dec.target == TCBR_T_CBUF) begin
            sel16 = match_value_shadow_n[dec.chan];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_q <= TCBR_RST_TEMP;
        end else if (bus_i.wr && dec.target == TCBR_T_TEMP) begin
            temp_q <= bus_i.wdata;
        end else if (wr_lo && dec.target != TCBR_T_NONE && dec.target != TCBR_T_FLAGS
                     && dec.target != TCBR_T_VALID) begin
            temp_q <= bus_i.wdata;
        end else if (rd_lo && dec.target != TCBR_T_NONE && dec.target != TCBR_T_TEMP
                     && dec.target != TCBR_T_FLAGS && dec.target != TCBR_T_VALID) begin
            temp_q <= sel16[15:8];
        end
    end

    // TOP from period except frequency mode
    assign top_value = frequency_waveform_mode_i ? match_value_n[0] : cycle_length;
    assign at_top = (count_q == top_value);
    assign update = count_tick_i && at_top && !count_we;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= TCBR_RST_COUNT;
        end else if (count_we) begin
            count_q <= wword;
        end else if (count_tick_i) begin
            if (at_top) begin
                count_q <= TCBR_RST_COUNT;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            update_q <= 1'b0;
        end else begin
            update_q <= update;
        end
    end

    tcbr_buffered_reg #(
        .RESET_VALUE(TCBR_RST_PER),
        .RESET_SHADOW(TCBR_RST_PBUF),
        .GATE_BY_VALID(1'b1)
    ) u_period (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .value_we_i(per_we),
        .shadow_we_i(pbuf_we),
        .wdata_i(wword),
        .update_i(update),
        .value_o(cycle_length),
        .shadow_o(cycle_length_shadow),
        .valid_o(cycle_length_shadow_valid)
    );

    assign flag_clear = (bus_i.wr && dec.target == TCBR_T_FLAGS)
                        ? bus_i.wdata[TCBR_FLAG_CMP_LSB +: NUM_CHAN] : '0;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : gen_chan
            tcbr_buffered_reg #(
                .RESET_VALUE(TCBR_RST_CMP),
                .RESET_SHADOW(TCBR_RST_CBUF),
                .GATE_BY_VALID(1'b0)
            ) u_cmp (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .value_we_i(cmp_we[g]),
                .shadow_we_i(cbuf_we[g]),
                .wdata_i(wword),
                .update_i(update),
                .value_o(match_value_n[g]),
                .shadow_o(match_value_shadow_n[g]),
                .valid_o(match_shadow_valid_n[g])
            );

            tcbr_match_flag u_match (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .count_i(count_q),
                .value_i(match_value_n[g]),
                .clear_i(flag_clear[g]),
                .match_o(match_q[g]),
                .flag_o(flag_q[g])
            );
        end
    endgenerate

    // Status bytes seen by software
    always_comb begin
        buffer_valid_control = 8'h00;
        buffer_valid_control[TCBR_VALID_PER_BIT] = cycle_length_shadow_valid;
        buffer_valid_control[TCBR_VALID_CMP_LSB +: NUM_CHAN] = match_shadow_valid_n;
        flag_byte = 8'h00;
        flag_byte[TCBR_FLAG_CMP_LSB +: NUM_CHAN] = flag_q;
    end

    always_comb begin
        rd_next = 8'h00;
        if (dec.target == TCBR_T_TEMP) begin
            rd_next = temp_q;
        end else if (dec.target == TCBR_T_FLAGS) begin
            rd_next = flag_byte;
        end else if (dec.target == TCBR_T_VALID) begin
            rd_next = buffer_valid_control;
        end else if (dec.target != TCBR_T_NONE) begin
            rd_next = dec.high ? temp_q : sel16[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_q <= rd_next;
        end
    end

    assign rdata_o = rdata_q;
    assign count_value_o = count_q;
    assign match_o = match_q;
    assign match_flag_o = flag_q;
    assign update_o = update_q;

endmodule : tcbr_timer_regs

// file: tcbr_pkg.sv
// Shared constants, types and address decode for the buffered timer register set
package tcbr_pkg;

    localparam int unsigned TCBR_NUM_CHAN = 3;
    localparam int unsigned TCBR_ADDR_W = 6;

    // Byte offsets on the peripheral register bus
    localparam logic [5:0] TCBR_OFF_VALID = 6'h07;
    localparam logic [5:0] TCBR_OFF_FLAGS = 6'h0B;
    localparam logic [5:0] TCBR_OFF_TEMP = 6'h0F;
    localparam logic [5:0] TCBR_OFF_COUNT = 6'h20;
    localparam logic [5:0] TCBR_OFF_PER = 6'h26;
    localparam logic [5:0] TCBR_OFF_CMP_BASE = 6'h28;
    localparam logic [5:0] TCBR_OFF_CMP_STRIDE = 6'h02;
    localparam logic [5:0] TCBR_OFF_PBUF = 6'h36;
    localparam logic [5:0] TCBR_OFF_CBUF_BASE = 6'h38;
    localparam logic [5:0] TCBR_OFF_CBUF_STRIDE = 6'h01;
    localparam logic [5:0] TCBR_OFF_HIGH = 6'h01;

    // Field positions
    localparam int unsigned TCBR_FLAG_CMP_LSB = 4;
    localparam int unsigned TCBR_VALID_PER_BIT = 0;
    localparam int unsigned TCBR_VALID_CMP_LSB = 1;

    // Reset values
    localparam logic [7:0] TCBR_RST_TEMP = 8'h00;
    localparam logic [15:0] TCBR_RST_COUNT = 16'h0000;
    localparam logic [15:0] TCBR_RST_PER = 16'hFFFF;
    localparam logic [15:0] TCBR_RST_CMP = 16'h0000;
    localparam logic [15:0] TCBR_RST_PBUF = 16'hFFFF;
    localparam logic [15:0] TCBR_RST_CBUF = 16'h0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tcbr_bus_req_type;

    typedef enum logic [3:0] {
        TCBR_T_NONE = 4'b0000,
        TCBR_T_TEMP = 4'b0001,
        TCBR_T_COUNT = 4'b0010,
        TCBR_T_PER = 4'b0011,
        TCBR_T_CMP = 4'b0100,
        TCBR_T_PBUF = 4'b0101,
        TCBR_T_CBUF = 4'b0110,
        TCBR_T_FLAGS = 4'b0111,
        TCBR_T_VALID = 4'b1000
    } tcbr_target_type;

    typedef struct packed {
        tcbr_target_type target;
        logic [1:0] chan;
        logic high;
    } tcbr_decode_type;

    // Byte address to register, channel and byte half; first match in channel order wins
    function automatic tcbr_decode_type tcbr_decode(input logic [5:0] addr);
        tcbr_decode_type d;
        logic found;
        d.target = TCBR_T_NONE;
        d.chan = 2'b00;
        d.high = 1'b0;
        found = 1'b0;
        if (addr == TCBR_OFF_TEMP) begin
            d.target = TCBR_T_TEMP;
            found = 1'b1;
        end else if (addr == TCBR_OFF_FLAGS) begin
            d.target = TCBR_T_FLAGS;
            found = 1'b1;
        end else if (addr == TCBR_OFF_VALID) begin
            d.target = TCBR_T_VALID;
            found = 1'b1;
        end else if (addr == TCBR_OFF_COUNT || addr == TCBR_OFF_COUNT + TCBR_OFF_HIGH) begin
            d.target = TCBR_T_COUNT;
            d.high = (addr != TCBR_OFF_COUNT);
            found = 1'b1;
        end else if (addr == TCBR_OFF_PER || addr == TCBR_OFF_PER + TCBR_OFF_HIGH) begin
            d.target = TCBR_T_PER;
            d.high = (addr != TCBR_OFF_PER);
            found = 1'b1;
        end else if (addr == TCBR_OFF_PBUF || addr == TCBR_OFF_PBUF + TCBR_OFF_HIGH) begin
            d.target = TCBR_T_PBUF;
            d.high = (addr != TCBR_OFF_PBUF);
            found = 1'b1;
        end
        for (int n = 0; n < TCBR_NUM_CHAN; n++) begin
            if (!found && addr == 6'(TCBR_OFF_CMP_BASE + n * TCBR_OFF_CMP_STRIDE)) begin
                d.target = TCBR_T_CMP;
                d.chan = 2'(n);
                found = 1'b1;
            end else if (!found && addr == 6'(TCBR_OFF_CMP_BASE + n * TCBR_OFF_CMP_STRIDE + TCBR_OFF_HIGH)) begin
                d.target = TCBR_T_CMP;
                d.chan = 2'(n);
                d.high = 1'b1;
                found = 1'b1;
            end
        end
        for (int n = 0; n < TCBR_NUM_CHAN; n++) begin
            if (!found && addr == 6'(TCBR_OFF_CBUF_BASE + n * TCBR_OFF_CBUF_STRIDE)) begin
                d.target = TCBR_T_CBUF;
                d.chan = 2'(n);
                found = 1'b1;
            end else if (!found && addr == 6'(TCBR_OFF_CBUF_BASE + n * TCBR_OFF_CBUF_STRIDE + TCBR_OFF_HIGH)) begin
                d.target = TCBR_T_CBUF;
                d.chan = 2'(n);
                d.high = 1'b1;
                found = 1'b1;
            end
        end
        return d;
    endfunction : tcbr_decode

endpackage : tcbr_pkg

// file: tcbr_buffered_reg.sv
// Register with a shadow copy that is transferred on an update condition
`timescale 1ns/1ps
module tcbr_buffered_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] RESET_SHADOW = 16'h0000,
    parameter bit GATE_BY_VALID = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic value_we_i,
    input wire logic shadow_we_i,
    input wire logic [15:0] wdata_i,
    input wire logic update_i,
    output logic [15:0] value_o,
    output logic [15:0] shadow_o,
    output logic valid_o
);
    import tcbr_pkg::*;

    logic [15:0] value_q;
    logic [15:0] shadow_q;
    logic valid_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            value_q <= RESET_VALUE;
        end else if (value_we_i) begin
            value_q <= wdata_i;
        end else if (update_i && (valid_q || !GATE_BY_VALID)) begin
            value_q <= shadow_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shadow_q <= RESET_SHADOW;
        end else if (shadow_we_i) begin
            shadow_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_q <= 1'b0;
        end else if (shadow_we_i) begin
            valid_q <= 1'b1;
        end else if (update_i) begin
            valid_q <= 1'b0;
        end
    end

    assign value_o = value_q;
    assign shadow_o = shadow_q;
    assign valid_o = valid_q;

endmodule : tcbr_buffered_reg

// file: tcbr_match_flag.sv
// Comparator with registered match output and sticky match flag
`timescale 1ns/1ps
module tcbr_match_flag (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] count_i,
    input wire logic [15:0] value_i,
    input wire logic clear_i,
    output logic match_o,
    output logic flag_o
);
    import tcbr_pkg::*;

    logic equal;
    logic match_q;
    logic flag_q;

    assign equal = (count_i == value_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= equal;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_q <= 1'b0;
        end else if (equal) begin
            flag_q <= 1'b1;
        end else if (clear_i) begin
            flag_q <= 1'b0;
        end
    end

    assign match_o = match_q;
    assign flag_o = flag_q;

endmodule : tcbr_match_flag

// file: tcbr_timer_regs_monitor.sv
// Assertion checker for the buffered timer register set
`timescale 1ns/1ps
module tcbr_timer_regs_monitor #(
    parameter int unsigned NUM_CHAN = tcbr_pkg::TCBR_NUM_CHAN
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire tcbr_pkg::tcbr_bus_req_type bus_i,
    input wire logic count_tick_i,
    input wire logic frequency_waveform_mode_i,
    input wire logic [7:0] rdata_o,
    input wire logic [15:0] count_value_o,
    input wire logic [NUM_CHAN-1:0] match_o,
    input wire logic [NUM_CHAN-1:0] match_flag_o,
    input wire logic update_o
);
    import tcbr_pkg::*;
    logic count_wr;
    logic [NUM_CHAN-1:0] clr;
    assign count_wr = bus_i.wr && bus_i.addr == TCBR_OFF_COUNT + TCBR_OFF_HIGH;
    assign clr = (bus_i.wr && bus_i.addr == TCBR_OFF_FLAGS) ? NUM_CHAN'(bus_i.wdata >> TCBR_FLAG_CMP_LSB) : '0;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_rd_lo;
        bus_i.rd && !bus_i.wr && bus_i.addr == TCBR_OFF_COUNT && !count_tick_i;
    endsequence
    sequence s_idle;
        !bus_i.rd && !bus_i.wr;
    endsequence
    sequence s_rd_hi;
        bus_i.rd && !bus_i.wr && bus_i.addr == TCBR_OFF_COUNT + TCBR_OFF_HIGH;
    endsequence
    AST_COUNT_HOLD: assert property (!count_tick_i && !count_wr |=> $stable(count_value_o))
        else $error("count moved without tick or write");
    AST_COUNT_STEP: assert property (count_tick_i && !count_wr |=>
        count_value_o == $past(count_value_o) + 16'h0001 || count_value_o == 16'h0000)
        else $error("count did not step or wrap");
    AST_UPD_CAUSE: assert property (update_o |-> $past(count_tick_i) || $past(count_tick_i, 2))
        else $error("update without tick");
    AST_MATCH_FLAG: assert property ((match_o & ~match_flag_o) == '0)
        else $error("match without flag");
    AST_FLAG_RISE: assert property (1'b1 |=> (match_flag_o & ~$past(match_flag_o) & ~match_o) == '0)
        else $error("flag rose without match");
    AST_FLAG_STICKY: assert property (1'b1 |=> ($past(match_flag_o) & ~$past(clr) & ~match_flag_o) == '0)
        else $error("flag dropped without clear");
    AST_FLAG_CLR: assert property (clr != '0 |=> ($past(clr) & match_flag_o & ~match_o) == '0)
        else $error("flag not cleared");
    AST_RD_HOLD: assert property (!bus_i.rd |=> $stable(rdata_o))
        else $error("read data moved without read");
    AST_RD_UNMAP: assert property (bus_i.rd && !bus_i.wr && bus_i.addr == 6'h3F |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_LO: assert property (s_rd_lo |=> rdata_o == $past(count_value_o[7:0]))
        else $error("count low byte wrong");
    AST_RD_PAIR: assert property (s_rd_lo ##1 s_idle ##1 s_rd_hi |=>
        rdata_o == $past(count_value_o[15:8], 3))
        else $error("count high byte not from latch");
endmodule : tcbr_timer_regs_monitor

// file: tcbr_host_model.sv
// Register bus host model making byte and word accesses
`timescale 1ns/1ps
module tcbr_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output tcbr_pkg::tcbr_bus_req_type bus_o
);
    import tcbr_pkg::*;
    initial bus_o = '0;
    // Released address and data show the inverse so stale values never match
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        bus_o = {w, !w, a, d};
        @(negedge clk_i);
        q = rdata_i;
        bus_o = {1'b0, 1'b0, ~a, ~d};
    endtask : acc
    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        logic [7:0] q;
        acc(1'b1, a, d[7:0], q);
        acc(1'b1, a + 6'h01, d[15:8], q);
    endtask : wr16
    task automatic rd16(input logic [5:0] a, output logic [15:0] q);
        acc(1'b0, a, 8'h00, q[7:0]);
        acc(1'b0, a + 6'h01, 8'h00, q[15:8]);
    endtask : rd16
endmodule : tcbr_host_model

// file: tcbr_timer_regs_tb_top.sv
// Self-checking bench for the buffered timer register set
`timescale 1ns/1ps
module tcbr_timer_regs_tb_top;
    import tcbr_pkg::*;
    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] rst;
        logic [15:0] val;
    } tcbr_row_type;
    localparam tcbr_row_type ROWS [7] = '{{6'h20, 16'h0000, 16'h1234}, {6'h26, 16'hFFFF, 16'h0003},
        {6'h28, 16'h0000, 16'h0102}, {6'h2A, 16'h0000, 16'h0203}, {6'h2C, 16'h0000, 16'h0304},
        {6'h36, 16'hFFFF, 16'h0006}, {6'h38, 16'h0000, 16'h0005}};
    logic clk_i;
    logic rst_b_i;
    logic tick;
    logic fmode;
    logic upd;
    logic [7:0] rdata;
    logic [7:0] b;
    logic [15:0] count_val;
    logic [2:0] mt;
    logic [15:0] q;
    logic [2:0] flag;
    tcbr_bus_req_type bus;
    int fails;
    int comparisons;
    tcbr_host_model host (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
    tcbr_timer_regs uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .count_tick_i(tick),
        .frequency_waveform_mode_i(fmode), .rdata_o(rdata), .count_value_o(count_val), .match_o(mt),
        .match_flag_o(flag), .update_o(upd));
    initial clk_i = 1'b0;
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] v;
        host.rd16(a, v);
        chk("word read", e, v);
    endtask : rchk
    // Ticks for n cycles and counts update pulses seen over n+3 cycles
    task automatic ticks(input int n, input logic [15:0] ups_exp);
        int ups;
        ups = 0;
        @(negedge clk_i);
        tick = 1'b1;
        for (int i = 0; i < n + 3; i++) begin
            @(negedge clk_i);
            if (i == n - 1) tick = 1'b0;
            if (upd === 1'b1) ups++;
        end
        chk("update pulses", ups_exp, 16'(ups));
    endtask : ticks
    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        fails = 0;
        comparisons = 0;
        rst_b_i = 1'b0;
        tick = 1'b0;
        fmode = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        for (int r = 0; r < 7; r++) begin
            rchk(ROWS[r].addr, ROWS[r].rst);
            host.wr16(ROWS[r].addr, ROWS[r].val);
            rchk(ROWS[r].addr, ROWS[r].val);
        end
        host.acc(1'b1, 6'h0F, 8'h5A, b);
        host.acc(1'b0, 6'h0F, 8'h00, b);
        chk("byte latch", 16'h005A, {8'h00, b});
        // High byte alone commits with the latch content
        host.acc(1'b1, 6'h3B, 8'hC3, b);
        host.acc(1'b1, 6'h07, 8'hFF, b);
        host.acc(1'b0, 6'h07, 8'h00, b);
        chk("valid byte", 16'h000B, {8'h00, b});
        host.acc(1'b0, 6'h3F, 8'h00, b);
        chk("unmapped", 16'h0000, {8'h00, b});
        host.wr16(6'h20, 16'h0000);
        ticks(4, 16'h0001);
        chk("count", 16'h0000, count_val);
        rchk(6'h26, 16'h0006);
        rchk(6'h28, 16'h0005);
        rchk(6'h2A, 16'h0000);
        rchk(6'h2C, 16'hC35A);
        host.acc(1'b0, 6'h07, 8'h00, b);
        chk("valid cleared", 16'h0000, {8'h00, b});
        // Channel 1 still matches, so its flag is set again
        host.acc(1'b1, 6'h0B, 8'h70, b);
        host.acc(1'b0, 6'h0B, 8'h00, b);
        chk("flag byte", 16'h0020, {8'h00, b});
        chk("flag port", 16'h0002, {13'h0000, flag});
        chk("match port", 16'h0002, {13'h0000, mt});
        fmode = 1'b1;
        ticks(6, 16'h0001);
        chk("count frequency mode", 16'h0000, count_val);
        fmode = 1'b0;
        ticks(6, 16'h0000);
        chk("count normal mode", 16'h0006, count_val);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("count in reset", 16'h0000, count_val);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        chk("flags after reset", 16'h0007, {13'h0000, flag});
        rchk(6'h26, 16'hFFFF);
        rchk(6'h36, 16'hFFFF);
        conclude();
    end
endmodule : tcbr_timer_regs_tb_top
bind tcbr_timer_regs tcbr_timer_regs_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus_i(bus_i), .count_tick_i(count_tick_i), .frequency_waveform_mode_i(frequency_waveform_mode_i),
    .rdata_o(rdata_o), .count_value_o(count_value_o), .match_o(match_o), .match_flag_o(match_flag_o),
    .update_o(update_o));
